//--- inc/ectd_map.vh
// register offsets, field positions and trap codes of the error trap dispatch block
`ifndef ECTD_MAP_VH
`define ECTD_MAP_VH
`define ECTD_OFF_CTRL 8'h00
`define ECTD_OFF_AFSR 8'h04
`define ECTD_OFF_STATE 8'h08
`define ECTD_OFF_IRQ_STAT 8'h0C
`define ECTD_OFF_IRQ_MASK 8'h10
`define ECTD_OFF_TPC 8'h14
`define ECTD_OFF_TRAP 8'h18
// control register fields
`define ECTD_CTRL_UGE_HANDLER 0
`define ECTD_CTRL_WEAK_DETECTION_FLAG 1
`define ECTD_CTRL_DEGRADED_TRAP_MASK 2
`define ECTD_CTRL_UNCORRECTABLE_TRAP_MASK 3
`define ECTD_CTRL_ADE_MASK 4
`define ECTD_CTRL_RESET 5'h00
// status register fields
`define ECTD_AFSR_DG 0
`define ECTD_AFSR_UE 1
// trap kinds
`define ECTD_TRAP_NONE 4'h0
`define ECTD_TRAP_SADE 4'h1
`define ECTD_TRAP_MADE 4'h2
`define ECTD_TRAP_IAE 4'h3
`define ECTD_TRAP_DAE 4'h4
`define ECTD_TRAP_ECC 4'h5
// interrupt status bits
`define ECTD_IRQ_FATAL 0
`define ECTD_IRQ_ESTATE 1
`define ECTD_IRQ_TRAP 2
`define ECTD_IRQ_PEND 3
`define ECTD_IRQ_W 4
`define ECTD_RESP_OKAY 2'h0
`define ECTD_RESP_SLVERR 2'h2
`endif

//--- core/ectd_error_dispatch.v
// error class trap dispatch for one thread, with AXI4-Lite registers
//Contract
//- fatal error: enter fatal state, then notify system; system halts.
//- error-state transition error: enter error state, then signal watchdog reset; code ignores it while the weak detection flag is 1.
//- instruction urgent: single trap if handler flag 0, multiple trap if 1.
//- async urgent: single trap if unmasked, else notification held pending.
//- instruction access: access exception if flag 0, multiple trap if 1.
//- data access: access exception if flag 0, multiple trap if 1.
//- ECC trap may fire with empty status register; software ignores it.
//- status write while restrainable pending overwrites the recorded information.
//- after uncorrectable trap, status write clears pending degraded indication.
//- after degraded trap, status write clears pending uncorrectable indication.
//- TLB-write instruction urgent: saved PC is updating instruction or one before.
//- TLB write error detected only at trap return or exception signalling.
//- other instruction urgent errors: saved PC is following instruction.
//- access errors: saved PC is the faulting instruction, precise.
//- masked async urgent is deferred, trap delivered once mask removed.
//- separate masks suppress ECC trap for degraded and uncorrectable errors.
`timescale 1ns/1ns
`include "ectd_map.vh"
module ectd_error_dispatch (
   input wire aclk,
   input wire aresetn,
   input wire fatal_error,
   input wire estate_error,
   input wire instruction_urgent_error,
   input wire iue_tlb_write,
   input wire async_urgent_error,
   input wire instruction_access_error,
   input wire data_access_error,
   input wire degraded_error,
   input wire uncorrectable_error,
   input wire trap_return,
   input wire [63:0] err_pc,
   input wire [63:0] err_npc,
   input wire [31:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [31:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   output reg trap_valid,
   output reg [3:0] trap_kind,
   output reg [63:0] saved_trap_pc,
   output reg fatal_notify,
   output reg watchdog_reset,
   output reg halted,
   output wire irq
);
   ////////////////////////////////////////////////////////////////////////////
   localparam ST_RUN = 3'b001;
   localparam ST_FATAL = 3'b010;
   localparam ST_ESTATE = 3'b100;

   function known_off;
      input [7:0] a;
      begin
         known_off = (a == `ECTD_OFF_CTRL) || (a == `ECTD_OFF_AFSR) ||
            (a == `ECTD_OFF_STATE) || (a == `ECTD_OFF_IRQ_STAT) ||
            (a == `ECTD_OFF_IRQ_MASK) || (a == `ECTD_OFF_TPC) || (a == `ECTD_OFF_TRAP);
      end
   endfunction

   reg [2:0] state_reg;
   reg [4:0] ctrl_reg;
   reg [1:0] afsr_reg;
   reg [1:0] rte_pend_reg;
   reg [1:0] last_ecc_reg;
   reg ade_pend_reg;
   reg tlb_pend_reg;
   reg [63:0] tlb_pc_reg;
   reg [3:0] irq_stat_reg;
   reg [3:0] irq_mask_reg;
   reg aw_hold_reg;
   reg w_hold_reg;
   reg [7:0] aw_addr_reg;
   reg [31:0] w_data_reg;
   reg [3:0] w_strb_reg;

   wire handler = ctrl_reg[`ECTD_CTRL_UGE_HANDLER];
   wire weak_detection_flag = ctrl_reg[`ECTD_CTRL_WEAK_DETECTION_FLAG];
   wire ade_masked = handler | weak_detection_flag | ctrl_reg[`ECTD_CTRL_ADE_MASK];

   ////////////////////////////////////////////////////////////////////////////
   // write channel: address and data taken in either order
   assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
   assign s_axi_wready = !w_hold_reg && !s_axi_bvalid;
   wire aw_fire = s_axi_awvalid && s_axi_awready;
   wire w_fire = s_axi_wvalid && s_axi_wready;
   wire have_aw = aw_hold_reg || aw_fire;
   wire have_w = w_hold_reg || w_fire;
   wire wr_go = have_aw && have_w;
   wire [7:0] wr_addr = aw_hold_reg ? aw_addr_reg : s_axi_awaddr[7:0];
   wire [31:0] wr_data = w_hold_reg ? w_data_reg : s_axi_wdata;
   wire [3:0] wr_strb = w_hold_reg ? w_strb_reg : s_axi_wstrb;
   wire wr_hit = wr_go && (s_axi_awaddr[31:8] == 24'h000000 || aw_hold_reg) && known_off(wr_addr);
   wire wr_ok = wr_go && known_off(wr_addr);
   wire wr_low = wr_strb[0];
   wire afsr_wr = wr_ok && wr_low && (wr_addr == `ECTD_OFF_AFSR);

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_reg <= 1'b0;
         w_hold_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg <= 32'h00000000;
         w_strb_reg <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `ECTD_RESP_OKAY;
      end else begin
         if (aw_fire) begin
            aw_hold_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr[7:0];
         end
         if (w_fire) begin
            w_hold_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? `ECTD_RESP_OKAY : `ECTD_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // error classification
   wire running = (state_reg == ST_RUN);
   wire fatal_ev = running && fatal_error;
   wire estate_ev = running && !fatal_error && estate_error && !weak_detection_flag;
   wire urgent_ok = running && !fatal_error && !estate_error;
   // tlb write errors wait for trap return or another exception
   wire tlb_new = urgent_ok && instruction_urgent_error && iue_tlb_write && !weak_detection_flag;
   wire iue_now = urgent_ok && instruction_urgent_error && !iue_tlb_write && !weak_detection_flag;
   wire exc_any = iue_now || (urgent_ok && (instruction_access_error || data_access_error));
   wire tlb_fire = tlb_pend_reg && urgent_ok && (trap_return || exc_any);
   wire iue_ev = iue_now || tlb_fire;
   wire aue_ev = urgent_ok && async_urgent_error;
   // only while running, so a pending notification is never dropped without a trap
   wire ade_fire = urgent_ok && !ade_masked && (aue_ev || ade_pend_reg);
   wire iae_ev = urgent_ok && !weak_detection_flag && instruction_access_error;
   wire dae_ev = urgent_ok && !weak_detection_flag && data_access_error;
   // restrainable: trap mask per type
   wire [1:0] rte_all = rte_pend_reg | {uncorrectable_error, degraded_error};
   wire [1:0] rte_open = rte_all & ~{ctrl_reg[`ECTD_CTRL_UNCORRECTABLE_TRAP_MASK], ctrl_reg[`ECTD_CTRL_DEGRADED_TRAP_MASK]};
   // pending bit may survive an erased status; the trap still fires
   wire ecc_fire = urgent_ok && !handler && !weak_detection_flag && (rte_open != 2'b00);

   reg [3:0] kind_next;
   reg [63:0] pc_next;
   always @* begin
      kind_next = `ECTD_TRAP_NONE;
      pc_next = 64'h0000000000000000;
      if (iue_ev) begin
         kind_next = handler ? `ECTD_TRAP_MADE : `ECTD_TRAP_SADE;
         pc_next = tlb_fire ? tlb_pc_reg : err_npc;
      end else if (ade_fire) begin
         kind_next = `ECTD_TRAP_SADE;
         pc_next = err_npc;
      end else if (dae_ev) begin
         kind_next = handler ? `ECTD_TRAP_MADE : `ECTD_TRAP_DAE;
         pc_next = err_pc;
      end else if (iae_ev) begin
         kind_next = handler ? `ECTD_TRAP_MADE : `ECTD_TRAP_IAE;
         pc_next = err_pc;
      end else if (ecc_fire) begin
         kind_next = `ECTD_TRAP_ECC;
         pc_next = err_npc;
      end
   end
   wire ecc_taken = (kind_next == `ECTD_TRAP_ECC);
   wire trap_now = urgent_ok && (kind_next != `ECTD_TRAP_NONE);

   ////////////////////////////////////////////////////////////////////////////
   // state, pending notifications, trap outputs
   always @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= ST_RUN;
         fatal_notify <= 1'b0;
         watchdog_reset <= 1'b0;
         halted <= 1'b0;
         ade_pend_reg <= 1'b0;
         tlb_pend_reg <= 1'b0;
         tlb_pc_reg <= 64'h0000000000000000;
         rte_pend_reg <= 2'b00;
         last_ecc_reg <= 2'b00;
         afsr_reg <= 2'b00;
         trap_valid <= 1'b0;
         trap_kind <= `ECTD_TRAP_NONE;
         saved_trap_pc <= 64'h0000000000000000;
      end else begin
         fatal_notify <= 1'b0;
         watchdog_reset <= 1'b0;
         trap_valid <= trap_now;
         case (state_reg)
            ST_RUN: begin
               if (fatal_ev) begin
                  state_reg <= ST_FATAL;
               end else if (estate_ev) begin
                  state_reg <= ST_ESTATE;
               end
            end
            ST_FATAL: begin
               if (!halted) begin
                  fatal_notify <= 1'b1;
               end
               halted <= 1'b1;
            end
            ST_ESTATE: begin
               watchdog_reset <= 1'b1;
               state_reg <= ST_RUN;
            end
            default: state_reg <= ST_RUN;
         endcase
         if (trap_now) begin
            trap_kind <= kind_next;
            saved_trap_pc <= pc_next;
         end
         // pending state kept per thread until delivered or erased
         if (ade_fire) begin
            ade_pend_reg <= 1'b0;
         end else if (aue_ev) begin
            ade_pend_reg <= 1'b1;
         end
         if (tlb_new) begin
            tlb_pend_reg <= 1'b1;
            tlb_pc_reg <= err_pc;
         end else if (tlb_fire) begin
            tlb_pend_reg <= 1'b0;
         end
         if (ecc_taken) begin
            last_ecc_reg <= rte_open;
         end
         // record, deliver, or erase restrainable errors; new detection wins
         if (afsr_wr) begin
            afsr_reg <= wr_data[1:0] | {uncorrectable_error, degraded_error};
            rte_pend_reg <= (rte_pend_reg & ~{last_ecc_reg[0], last_ecc_reg[1]}) |
               {uncorrectable_error, degraded_error};
         end else begin
            afsr_reg <= afsr_reg | {uncorrectable_error, degraded_error};
            rte_pend_reg <= ecc_taken ? (rte_all & ~rte_open) : rte_all;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupt status, write one to clear, set wins
   wire [3:0] irq_ev = {ade_pend_reg, trap_now, estate_ev, fatal_ev};
   wire [3:0] irq_clr = (wr_ok && wr_low && wr_addr == `ECTD_OFF_IRQ_STAT) ? wr_data[3:0] : 4'h0;
   assign irq = |(irq_stat_reg & irq_mask_reg);

   always @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg <= `ECTD_CTRL_RESET;
         irq_stat_reg <= 4'h0;
         irq_mask_reg <= 4'h0;
      end else begin
         irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_ev;
         if (wr_ok && wr_low && wr_addr == `ECTD_OFF_CTRL) begin
            ctrl_reg <= wr_data[4:0];
         end
         if (wr_ok && wr_low && wr_addr == `ECTD_OFF_IRQ_MASK) begin
            irq_mask_reg <= wr_data[3:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read channel, one cycle answer
   assign s_axi_arready = !s_axi_rvalid;
   reg [31:0] rd_next;
   always @* begin
      case (s_axi_araddr[7:0])
         `ECTD_OFF_CTRL: rd_next = {27'h0000000, ctrl_reg};
         `ECTD_OFF_AFSR: rd_next = {28'h0000000, rte_pend_reg, afsr_reg};
         `ECTD_OFF_STATE: rd_next = {26'h0000000, tlb_pend_reg, ade_pend_reg, halted, state_reg};
         `ECTD_OFF_IRQ_STAT: rd_next = {28'h0000000, irq_stat_reg};
         `ECTD_OFF_IRQ_MASK: rd_next = {28'h0000000, irq_mask_reg};
         `ECTD_OFF_TPC: rd_next = saved_trap_pc[31:0];
         `ECTD_OFF_TRAP: rd_next = {28'h0000000, trap_kind};
         default: rd_next = 32'h00000000;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `ECTD_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_next;
         s_axi_rresp <= known_off(s_axi_araddr[7:0]) ? `ECTD_RESP_OKAY : `ECTD_RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   wire unused_ok = wr_hit;
endmodule

//--- testbench/ectd_error_dispatch_chk.sv
// port assertions of the error trap dispatch block
`timescale 1ns/1ns
`include "ectd_map.vh"
module ectd_chk (
   input wire aclk,
   input wire aresetn,
   input wire fatal_error,
   input wire estate_error,
   input wire instruction_urgent_error,
   input wire iue_tlb_write,
   input wire async_urgent_error,
   input wire instruction_access_error,
   input wire data_access_error,
   input wire trap_return,
   input wire [63:0] err_pc,
   input wire [63:0] err_npc,
   input wire trap_valid,
   input wire [3:0] trap_kind,
   input wire [63:0] saved_trap_pc,
   input wire fatal_notify,
   input wire watchdog_reset,
   input wire halted
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   wire hi = fatal_error | estate_error | halted;
   wire iue = instruction_urgent_error;
   property p_fatal; fatal_error && !halted |=> ##1 fatal_notify && halted; endproperty
   a_fatal: assert property (p_fatal)
      else $error("fatal notify missing");
   property p_halt; halted |=> halted; endproperty
   a_halt: assert property (p_halt)
      else $error("halt released");
   property p_wdr; estate_error && !fatal_error && !halted |=> ##1 watchdog_reset; endproperty
   a_wdr: assert property (p_wdr)
      else $error("watchdog reset missing");
   property p_iue;
      iue && !iue_tlb_write && !hi |=> trap_valid && saved_trap_pc == $past(err_npc)
         && (trap_kind == `ECTD_TRAP_SADE || trap_kind == `ECTD_TRAP_MADE);
   endproperty
   a_iue: assert property (p_iue)
      else $error("urgent trap wrong");
   property p_tlb;
      iue && iue_tlb_write && !hi && !trap_return && !async_urgent_error
         && !instruction_access_error && !data_access_error |=> !trap_valid;
   endproperty
   a_tlb: assert property (p_tlb)
      else $error("tlb error trapped early");
   property p_dae;
      data_access_error && !iue && !async_urgent_error && !hi |=> trap_valid
         && (trap_kind == `ECTD_TRAP_MADE
         || trap_kind == `ECTD_TRAP_DAE && saved_trap_pc == $past(err_pc));
   endproperty
   a_dae: assert property (p_dae)
      else $error("data access trap wrong");
   property p_iae;
      instruction_access_error && !data_access_error && !iue && !async_urgent_error && !hi
         |=> trap_valid && (trap_kind == `ECTD_TRAP_MADE
         || trap_kind == `ECTD_TRAP_IAE && saved_trap_pc == $past(err_pc));
   endproperty
   a_iae: assert property (p_iae)
      else $error("instruction access trap wrong");
   property p_pc_hold; !trap_valid |-> $stable(saved_trap_pc); endproperty
   a_pc_hold: assert property (p_pc_hold)
      else $error("saved pc moved without trap");
   c_made: cover property (trap_valid && trap_kind == `ECTD_TRAP_MADE);
   c_ecc: cover property (trap_valid && trap_kind == `ECTD_TRAP_ECC);
   c_wdr: cover property (watchdog_reset);
endmodule
bind ectd_error_dispatch ectd_chk u_chk (.aclk(aclk), .aresetn(aresetn),
   .fatal_error(fatal_error), .estate_error(estate_error),
   .instruction_urgent_error(instruction_urgent_error), .iue_tlb_write(iue_tlb_write),
   .async_urgent_error(async_urgent_error), .instruction_access_error(instruction_access_error),
   .data_access_error(data_access_error), .trap_return(trap_return), .err_pc(err_pc),
   .err_npc(err_npc), .trap_valid(trap_valid), .trap_kind(trap_kind),
   .saved_trap_pc(saved_trap_pc), .fatal_notify(fatal_notify),
   .watchdog_reset(watchdog_reset), .halted(halted));

//--- testbench/test_error_class_trap_dispatch.sv
// self-checking bench of the error trap dispatch block
`timescale 1ns/1ns
`include "ectd_map.vh"
module test_error_class_trap_dispatch;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [9:0] ev = '0;
   logic [63:0] pc = '0, lp;
   logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rd;
   logic [3:0] lk;
   logic [1:0] rr;
   logic [15:0] tbl [10];
   wire awready, wready, bvalid, arready, rvalid, trap_valid, fatal_notify, watchdog_reset;
   wire halted, irq;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [3:0] trap_kind;
   wire [63:0] saved_trap_pc;
   int n_errors = 0, n_checks = 0, cyc = 0, ntrap = 0, nf = 0, nw = 0;
   always #10 aclk = ~aclk;
   ectd_error_dispatch dut (.aclk(aclk), .aresetn(aresetn), .fatal_error(ev[0]),
      .estate_error(ev[1]), .instruction_urgent_error(ev[2]), .iue_tlb_write(ev[9]),
      .async_urgent_error(ev[3]), .instruction_access_error(ev[4]),
      .data_access_error(ev[5]), .degraded_error(ev[6]), .uncorrectable_error(ev[7]),
      .trap_return(ev[8]), .err_pc(pc), .err_npc(pc + 64'h4), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .trap_valid(trap_valid), .trap_kind(trap_kind),
      .saved_trap_pc(saved_trap_pc), .fatal_notify(fatal_notify),
      .watchdog_reset(watchdog_reset), .halted(halted), .irq(irq));
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge aclk) begin
      cyc++;
      if (trap_valid === 1'b1) begin
         ntrap++;
         lk = trap_kind;
         lp = saved_trap_pc;
      end
      if (fatal_notify === 1'b1) nf++;
      if (watchdog_reset === 1'b1) nw++;
      if (cyc == 5000) begin
         n_errors++;
         close_out;
      end
   end
   task close_out;
      if (n_errors == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input [63:0] g, input [63:0] e);
      n_checks++;
      if (g !== e) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wr(input [7:0] a, input [31:0] d);
      @(posedge aclk);
      awaddr <= {24'h0, a};
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      chk(bresp, `ECTD_RESP_OKAY);
   endtask
   task automatic rchk(input [7:0] a, input [31:0] m, input [31:0] e);
      @(posedge aclk);
      araddr <= {24'h0, a};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rd = rdata;
      rr = rresp;
      rready <= 1'b0;
      chk(rd & m, e);
   endtask
   task automatic pulse(input [9:0] b, input [63:0] p);
      @(posedge aclk);
      ev <= b;
      pc <= p;
      @(posedge aclk);
      ev <= '0;
   endtask
   // sel: 1 faulting pc, 2 next pc, 0 pc not compared
   task automatic expect_trap(input [31:0] s, input [3:0] k, input [1:0] sel, input [63:0] p);
      repeat (5) @(posedge aclk);
      #1;
      chk(ntrap, s);
      if (s != 0) chk(lk, k);
      if (s != 0 && sel != 0) chk(lp, sel == 2'h1 ? p : p + 64'h4);
      ntrap = 0;
   endtask
   task automatic race(input [31:0] m, input [9:0] a, input [9:0] b);
      wr(`ECTD_OFF_CTRL, m);
      pulse(a, 64'h0);
      expect_trap(0, 4'h0, 2'h0, 64'h0);
      pulse(b, 64'h0);
      expect_trap(1, `ECTD_TRAP_ECC, 2'h0, 64'h0);
      wr(`ECTD_OFF_AFSR, 32'h0);
      wr(`ECTD_OFF_CTRL, 32'h0);
      expect_trap(0, 4'h0, 2'h0, 64'h0);
      rchk(`ECTD_OFF_AFSR, 32'hF, 32'h0);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      tbl = '{{4'h0, 4'h2, `ECTD_TRAP_SADE, 4'h2}, {4'h1, 4'h2, `ECTD_TRAP_MADE, 4'h0},
         {4'h0, 4'h3, `ECTD_TRAP_SADE, 4'h0}, {4'h0, 4'h4, `ECTD_TRAP_IAE, 4'h1},
         {4'h1, 4'h4, `ECTD_TRAP_MADE, 4'h0}, {4'h0, 4'h5, `ECTD_TRAP_DAE, 4'h1},
         {4'h1, 4'h5, `ECTD_TRAP_MADE, 4'h0}, {4'h0, 4'h6, `ECTD_TRAP_ECC, 4'h0},
         {4'h0, 4'h7, `ECTD_TRAP_ECC, 4'h0}, {4'h0, 4'h2, `ECTD_TRAP_SADE, 4'h2}};
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      rchk(`ECTD_OFF_CTRL, 32'h1F, 32'h0);
      rchk(`ECTD_OFF_TRAP, 32'hF, 32'h0);
      chk(halted, 1'b0);
      for (int i = 0; i < 10; i++) begin
         wr(`ECTD_OFF_CTRL, {28'h0, tbl[i][15:12]});
         pulse(10'h001 << tbl[i][11:8], 64'h1000 + 64'(i) * 64'h10);
         expect_trap(1, tbl[i][7:4], tbl[i][1:0], 64'h1000 + 64'(i) * 64'h10);
      end
      wr(`ECTD_OFF_IRQ_MASK, 32'h0);
      chk(irq, 1'b0);
      wr(`ECTD_OFF_IRQ_MASK, 32'h4);
      chk(irq, 1'b1);
      wr(`ECTD_OFF_IRQ_STAT, 32'h4);
      chk(irq, 1'b0);
      wr(`ECTD_OFF_CTRL, 32'h10);
      pulse(10'h008, 64'h2000);
      expect_trap(0, 4'h0, 2'h0, 64'h0);
      wr(`ECTD_OFF_CTRL, 32'h0);
      expect_trap(1, `ECTD_TRAP_SADE, 2'h0, 64'h0);
      pulse(10'h204, 64'h3000);
      expect_trap(0, 4'h0, 2'h0, 64'h0);
      pulse(10'h100, 64'h3100);
      expect_trap(1, `ECTD_TRAP_SADE, 2'h1, 64'h3000);
      race(32'h4, 10'h040, 10'h080);
      race(32'h8, 10'h080, 10'h040);
      wr(`ECTD_OFF_CTRL, 32'hC);
      pulse(10'h040, 64'h0);
      expect_trap(0, 4'h0, 2'h0, 64'h0);
      wr(`ECTD_OFF_AFSR, 32'h2);
      rchk(`ECTD_OFF_AFSR, 32'h3, 32'h2);
      wr(`ECTD_OFF_CTRL, 32'h0);
      expect_trap(1, `ECTD_TRAP_ECC, 2'h0, 64'h0);
      rchk(8'h40, 32'hFFFFFFFF, 32'h0);
      chk(rr, `ECTD_RESP_SLVERR);
      pulse(10'h002, 64'h0);
      repeat (4) @(posedge aclk);
      #1;
      chk(nw, 1);
      pulse(10'h001, 64'h0);
      repeat (4) @(posedge aclk);
      #1;
      chk(nf, 1);
      chk(halted, 1'b1);
      close_out;
   end
endmodule
